//--- rtl/asp_defines.svh
// constants of the asynchronous serial port
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH
`define ASP_ADDR_CTRL 2'h0
`define ASP_ADDR_BUF 2'h1
`define ASP_ADDR_BAUD 2'h2
`define ASP_CTRL_RX_DONE 0
`define ASP_CTRL_TX_DONE 1
`define ASP_CTRL_RX_NINTH 2
`define ASP_CTRL_TX_NINTH 3
`define ASP_CTRL_RX_EN 4
`define ASP_CTRL_FILTER 5
`define ASP_CTRL_MODE_LO 6
`define ASP_CTRL_MODE_HI 7
`define ASP_BAUD_DOUBLE 0
`define ASP_BAUD_TX_T2 1
`define ASP_BAUD_RX_T2 2
`define ASP_MODE_OFF 2'h0
`define ASP_MODE_FIXED 2'h2
`define ASP_CNT_LAST 4'hF
`define ASP_SMP_FIRST 4'h7
`define ASP_SMP_SECOND 4'h8
`define ASP_SMP_THIRD 4'h9
`define ASP_RSR_INIT 9'h1FF
`define ASP_TX_END_PAT 8'h01
`define ASP_ROLLS_10BIT 4'hA
`define ASP_ROLLS_11BIT 4'hB
`define ASP_BYTE_ZERO 8'h00
`endif

//--- rtl/asp_pkg.sv
// types of the asynchronous serial port
package asp_pkg;
  typedef enum logic [1:0] {ASP_RX_IDLE, ASP_RX_BITS, ASP_RX_WAIT} asp_rx_e;
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } asp_bus_s;
  typedef struct packed {
    logic [1:0] mode;
    logic multiprocessor_filter_bit;
    logic receive_enable;
    logic transmit_ninth_bit;
    logic received_ninth_bit;
    logic transmit_done_flag;
    logic receive_done_flag;
    logic rate_double_bit;
    logic transmit_clock_select;
    logic receive_clock_select;
    logic [7:0] serial_buffer;
    logic [8:0] tsr;
    logic tx_req;
    logic send;
    logic data_on;
    logic shifted;
    logic [3:0] tcnt;
    logic [3:0] rolls;
    logic [1:0] osc_cnt;
    logic t1_half;
    logic rxs1;
    logic rxs2;
    logic rxprev;
    asp_rx_e rstate;
    logic [3:0] rcnt;
    logic [8:0] rsr;
    logic [1:0] smp;
    logic txd;
    logic irq;
    logic [7:0] rdata;
  } asp_st_s;
endpackage : asp_pkg

//--- rtl/asp_uart.sv
// asynchronous serial port, 10-bit and 11-bit frame modes
//
// Contract
// - 10-bit frame: zero start, eight data bits lsb first, one stop.
// - 10-bit mode: accepted stop bit goes to the received ninth bit.
// - transmit and receive may each take their own timer as rate source.
// - 10-bit mode: buffer write requests transmit, loads one marker at bit nine.
// - frame starts after the next divide-by-16 rollover, not at the write.
// - start bit first, data output one bit later, first shift one bit after that.
// - zeros fill from top; final shift, send drop and done flag at tenth rollover.
// - sample at 16x; on falling edge reset counter and load all ones.
// - each bit sampled at counter states 7, 8, 9, majority of three wins.
// - nonzero first bit aborts back to edge search, else start bit shifts in.
// - data enter at bottom; start bit at top means final shift then load.
// - 10-bit load only when done flag clear and filter off or stop one.
// - 11-bit frame: start, eight data lsb first, ninth bit, one stop.
// - 11-bit fixed rate is osc/32 or osc/64; variable uses timer 1 or 2.
// - fixed rate uses osc/64 when rate double is zero, osc/32 when one.
// - timer 1 source: rate is 2^double/32 times the timer 1 overflow rate.
// - timer 2 source: rate is timer 2 overflow rate divided by 16.
// - 11-bit mode: buffer write requests transmit, loads transmit ninth bit.
// - 11-bit: first shift inserts stop one, then zeros; done at eleventh rollover.
// - 11-bit load only when done flag clear and filter off or ninth bit one.
// - 11-bit: edge search resumes one bit time after the final shift.
// - 11-bit: received stop bit never affects buffer, ninth bit or flag.
// - interrupt request is done flags ORed; hardware never clears them.
// - software writes to the done flags act like hardware set or clear.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`include "asp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module asp_uart (
  input wire logic clock,
  input wire logic rst_n,
  input wire asp_pkg::asp_bus_s bus,
  output logic [7:0] rdata,
  input wire logic rxd,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  output logic txd,
  output logic serial_irq
);
  import asp_pkg::*;

  asp_st_s st_r;
  asp_st_s st_nxt;
  logic ttick;
  logic rtick;
  logic tx_final;
  logic tx_begin;
  logic rx_start;
  logic rx_vote_pt;
  logic rx_vote;
  logic rx_load;
  logic rx_abort;

  // 16x tick for one direction
  function automatic logic asp_rate_tick(input logic [1:0] mode, input logic sel_t2, input logic dbl,
                                         input logic t1, input logic t1_half, input logic t2,
                                         input logic [1:0] osc);
    if (mode == `ASP_MODE_FIXED) begin
      asp_rate_tick = dbl ? osc[0] : &osc;
    end else if (sel_t2) begin
      asp_rate_tick = t2;
    end else begin
      asp_rate_tick = t1 && (dbl || t1_half);
    end
  endfunction : asp_rate_tick

  function automatic logic [7:0] asp_rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      asp_rev8[i] = v[7 - i];
    end
  endfunction : asp_rev8

  always_comb begin
    st_nxt = st_r;
    tx_final = 1'b0;
    tx_begin = 1'b0;
    rx_start = 1'b0;
    rx_vote_pt = 1'b0;
    rx_load = 1'b0;
    rx_abort = 1'b0;
    rx_vote = 1'b0;
    st_nxt.rxs1 = rxd;
    st_nxt.rxs2 = st_r.rxs1;
    st_nxt.osc_cnt = st_r.osc_cnt + 2'h1;
    if (timer1_ovf) begin
      st_nxt.t1_half = ~st_r.t1_half;
    end
    // independent rate sources per direction, except in fixed mode where both use the oscillator tick
    ttick = asp_rate_tick(st_r.mode, st_r.transmit_clock_select, st_r.rate_double_bit,
                          timer1_ovf, st_r.t1_half, timer2_ovf, st_r.osc_cnt);
    rtick = asp_rate_tick(st_r.mode, st_r.receive_clock_select, st_r.rate_double_bit,
                          timer1_ovf, st_r.t1_half, timer2_ovf, st_r.osc_cnt);

    // register writes; hardware sets below take priority
    if (bus.wr) begin
      case (bus.addr)
        `ASP_ADDR_CTRL: begin
          st_nxt.mode = bus.wdata[`ASP_CTRL_MODE_HI:`ASP_CTRL_MODE_LO];
          st_nxt.multiprocessor_filter_bit = bus.wdata[`ASP_CTRL_FILTER];
          st_nxt.receive_enable = bus.wdata[`ASP_CTRL_RX_EN];
          st_nxt.transmit_ninth_bit = bus.wdata[`ASP_CTRL_TX_NINTH];
          st_nxt.received_ninth_bit = bus.wdata[`ASP_CTRL_RX_NINTH];
          st_nxt.transmit_done_flag = bus.wdata[`ASP_CTRL_TX_DONE];
          st_nxt.receive_done_flag = bus.wdata[`ASP_CTRL_RX_DONE];
        end
        `ASP_ADDR_BAUD: begin
          st_nxt.rate_double_bit = bus.wdata[`ASP_BAUD_DOUBLE];
          st_nxt.transmit_clock_select = bus.wdata[`ASP_BAUD_TX_T2];
          st_nxt.receive_clock_select = bus.wdata[`ASP_BAUD_RX_T2];
        end
        default: begin
        end
      endcase
    end

    // transmitter, own divide-by-16 counter
    if (ttick) begin
      st_nxt.tcnt = st_r.tcnt + 4'h1;
      if (st_r.tcnt == `ASP_CNT_LAST) begin
        st_nxt.rolls = st_r.rolls + 4'h1;
        if (st_r.send) begin
          if (!st_r.data_on) begin
            st_nxt.data_on = 1'b1;
          end else if (st_r.shifted && st_r.tsr[8:1] == `ASP_TX_END_PAT) begin
            st_nxt.tsr = {1'b0, st_r.tsr[8:1]};
            st_nxt.send = 1'b0;
            st_nxt.data_on = 1'b0;
            st_nxt.transmit_done_flag = 1'b1;
            tx_final = 1'b1;
          end else begin
            // 11-bit first shift brings in the stop bit
            st_nxt.tsr = {st_r.mode[1] && !st_r.shifted, st_r.tsr[8:1]};
            st_nxt.shifted = 1'b1;
          end
        end else if (st_r.tx_req) begin
          st_nxt.send = 1'b1;
          st_nxt.tx_req = 1'b0;
          st_nxt.data_on = 1'b0;
          st_nxt.shifted = 1'b0;
          tx_begin = 1'b1;
        end
      end
    end
    if (bus.wr && bus.addr == `ASP_ADDR_BUF && st_r.mode != `ASP_MODE_OFF) begin
      // ninth position: marker in 10-bit mode, programmed bit in 11-bit modes
      st_nxt.tsr = {st_r.mode[1] ? st_r.transmit_ninth_bit : 1'b1, bus.wdata};
      st_nxt.tx_req = 1'b1;
      st_nxt.rolls = 4'h0;
    end
    st_nxt.txd = st_nxt.send ? (st_nxt.data_on & st_nxt.tsr[0]) : 1'b1;

    // receiver, own divide-by-16 counter
    if (!st_r.receive_enable || st_r.mode == `ASP_MODE_OFF) begin
      st_nxt.rstate = ASP_RX_IDLE;
    end else if (rtick) begin
      st_nxt.rxprev = st_r.rxs2;
      st_nxt.rcnt = st_r.rcnt + 4'h1;
      if (st_r.rcnt == `ASP_SMP_FIRST) begin
        st_nxt.smp[0] = st_r.rxs2;
      end
      if (st_r.rcnt == `ASP_SMP_SECOND) begin
        st_nxt.smp[1] = st_r.rxs2;
      end
      rx_vote = (st_r.smp[0] & st_r.smp[1]) | (st_r.smp[0] & st_r.rxs2) | (st_r.smp[1] & st_r.rxs2);
      rx_vote_pt = (st_r.rcnt == `ASP_SMP_THIRD);
      case (st_r.rstate)
        ASP_RX_IDLE: begin
          if (st_r.rxprev && !st_r.rxs2) begin
            st_nxt.rstate = ASP_RX_BITS;
            st_nxt.rcnt = 4'h0;
            st_nxt.rsr = `ASP_RSR_INIT;
            rx_start = 1'b1;
          end
        end
        ASP_RX_BITS: begin
          if (rx_vote_pt) begin
            st_nxt.rsr = {st_r.rsr[7:0], rx_vote};
            if (st_r.rsr == `ASP_RSR_INIT && rx_vote) begin
              st_nxt.rstate = ASP_RX_IDLE;
              rx_abort = 1'b1;
            end else if (!st_r.rsr[8]) begin
              // last sampled bit: stop bit in 10-bit mode, ninth bit otherwise
              if (!st_r.receive_done_flag && (!st_r.multiprocessor_filter_bit || rx_vote)) begin
                st_nxt.received_ninth_bit = rx_vote;
                st_nxt.serial_buffer = asp_rev8(st_r.rsr[7:0]);
                st_nxt.receive_done_flag = 1'b1;
                rx_load = 1'b1;
              end
              st_nxt.rstate = st_r.mode[1] ? ASP_RX_WAIT : ASP_RX_IDLE;
            end
          end
        end
        ASP_RX_WAIT: begin
          // stop bit time of an 11-bit frame is ignored
          if (rx_vote_pt) begin
            st_nxt.rstate = ASP_RX_IDLE;
          end
        end
        default: begin
          st_nxt.rstate = ASP_RX_IDLE;
        end
      endcase
    end

    st_nxt.irq = st_nxt.receive_done_flag | st_nxt.transmit_done_flag;

    st_nxt.rdata = `ASP_BYTE_ZERO;
    if (bus.rd) begin
      case (bus.addr)
        `ASP_ADDR_CTRL: st_nxt.rdata = {st_r.mode, st_r.multiprocessor_filter_bit, st_r.receive_enable,
                                        st_r.transmit_ninth_bit, st_r.received_ninth_bit,
                                        st_r.transmit_done_flag, st_r.receive_done_flag};
        `ASP_ADDR_BUF: st_nxt.rdata = st_r.serial_buffer;
        `ASP_ADDR_BAUD: st_nxt.rdata = {5'h00, st_r.receive_clock_select, st_r.transmit_clock_select,
                                        st_r.rate_double_bit};
        default: st_nxt.rdata = `ASP_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.rxs1 <= 1'b1;
      st_r.rxs2 <= 1'b1;
      st_r.rxprev <= 1'b1;
      st_r.txd <= 1'b1;
      st_r.rstate <= ASP_RX_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign txd = st_r.txd;
  assign serial_irq = st_r.irq;
  assign rdata = st_r.rdata;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_tx_start_bit: assert property (tx_begin |=> !txd ##0 st_r.send)
    else $error("start bit not driven");
  a_tx_idle_high: assert property (!st_r.send |-> txd)
    else $error("line not high outside frame");
  a_tx_frame_rolls: assert property (tx_final |-> (st_r.rolls + 4'h1) ==
                                     (st_r.mode[1] ? `ASP_ROLLS_11BIT : `ASP_ROLLS_10BIT))
    else $error("transmit done at wrong rollover");
  a_tx_done_set: assert property (tx_final |=> st_r.transmit_done_flag && !st_r.send)
    else $error("transmit done flag not set");
  a_rx_edge_load: assert property (rx_start |=> st_r.rsr == `ASP_RSR_INIT && st_r.rcnt == 4'h0)
    else $error("receive not primed on edge");
  a_rx_false_start: assert property (rx_abort |=> st_r.rstate == ASP_RX_IDLE && !rx_load)
    else $error("false start not rejected");
  a_rx_accept_gate: assert property (rx_load |-> !st_r.receive_done_flag &&
                                     (!st_r.multiprocessor_filter_bit || rx_vote))
    else $error("frame loaded against gate");
  a_rx_flag_ninth: assert property (rx_load |=> st_r.receive_done_flag && st_r.received_ninth_bit == $past(rx_vote))
    else $error("receive flag or ninth bit wrong");
  a_irq_flags: assert property (##1 serial_irq == (st_r.receive_done_flag | st_r.transmit_done_flag))
    else $error("request not OR of flags");
  a_sw_flag_write: assert property (bus.wr && bus.addr == `ASP_ADDR_CTRL && !rx_load |=>
                                    st_r.receive_done_flag == $past(bus.wdata[`ASP_CTRL_RX_DONE]))
    else $error("software flag write lost");
  a_rx_wait_resume: assert property (rx_load && st_r.mode[1] |=> st_r.rstate == ASP_RX_WAIT)
    else $error("11-bit receive did not wait a bit time");

  property p_rdata_idle;
    !bus.rd |=> rdata == `ASP_BYTE_ZERO;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not cleared after a read");

  property p_rdata_buffer;
    bus.rd && bus.addr == `ASP_ADDR_BUF |=> rdata == $past(st_r.serial_buffer);
  endproperty
  a_rdata_buffer: assert property (p_rdata_buffer)
    else $error("buffer read returned wrong byte");

  property p_tx_load_byte;
    bus.wr && bus.addr == `ASP_ADDR_BUF && st_r.mode != `ASP_MODE_OFF |=>
      st_r.tx_req && st_r.tsr[7:0] == $past(bus.wdata);
  endproperty
  a_tx_load_byte: assert property (p_tx_load_byte)
    else $error("buffer write did not load transmit byte");

  property p_tx_marker_bit;
    bus.wr && bus.addr == `ASP_ADDR_BUF && st_r.mode != `ASP_MODE_OFF && !st_r.mode[1] |=> st_r.tsr[8];
  endproperty
  a_tx_marker_bit: assert property (p_tx_marker_bit)
    else $error("marker not loaded at ninth position");

  property p_tx_ninth_load;
    bus.wr && bus.addr == `ASP_ADDR_BUF && st_r.mode[1] |=> st_r.tsr[8] == $past(st_r.transmit_ninth_bit);
  endproperty
  a_tx_ninth_load: assert property (p_tx_ninth_load)
    else $error("transmit ninth bit not loaded");

  property p_tx_data_route;
    st_r.send && st_r.data_on |-> txd == st_r.tsr[0];
  endproperty
  a_tx_data_route: assert property (p_tx_data_route)
    else $error("shift register output not on line");

  property p_tx_start_hold;
    st_r.send && !st_r.data_on |-> !txd;
  endproperty
  a_tx_start_hold: assert property (p_tx_start_hold)
    else $error("start bit not held low");

  property p_tx_begin_roll;
    tx_begin |-> st_r.tx_req && ttick && st_r.tcnt == `ASP_CNT_LAST;
  endproperty
  a_tx_begin_roll: assert property (p_tx_begin_roll)
    else $error("frame started off a rollover");

  property p_tx_count_step;
    ttick |=> st_r.tcnt == $past(st_r.tcnt) + 4'h1;
  endproperty
  a_tx_count_step: assert property (p_tx_count_step)
    else $error("transmit counter did not advance");

  property p_tx_count_hold;
    !ttick |=> $stable(st_r.tcnt);
  endproperty
  a_tx_count_hold: assert property (p_tx_count_hold)
    else $error("transmit counter moved without tick");

  property p_tx_done_cause;
    $rose(st_r.transmit_done_flag) |-> $past(tx_final) || $past(bus.wr && bus.addr == `ASP_ADDR_CTRL);
  endproperty
  a_tx_done_cause: assert property (p_tx_done_cause)
    else $error("transmit done flag set without cause");

  property p_rx_done_cause;
    $rose(st_r.receive_done_flag) |-> $past(rx_load) || $past(bus.wr && bus.addr == `ASP_ADDR_CTRL);
  endproperty
  a_rx_done_cause: assert property (p_rx_done_cause)
    else $error("receive done flag set without cause");

  property p_rx_off_idle;
    !st_r.receive_enable |=> st_r.rstate == ASP_RX_IDLE;
  endproperty
  a_rx_off_idle: assert property (p_rx_off_idle)
    else $error("receiver active while disabled");

  property p_rx_first_sample;
    rtick && st_r.receive_enable && st_r.mode != `ASP_MODE_OFF && st_r.rcnt == `ASP_SMP_FIRST |=>
      st_r.smp[0] == $past(st_r.rxs2);
  endproperty
  a_rx_first_sample: assert property (p_rx_first_sample)
    else $error("first sample not taken");

  property p_rx_second_sample;
    rtick && st_r.receive_enable && st_r.mode != `ASP_MODE_OFF && st_r.rcnt == `ASP_SMP_SECOND |=>
      st_r.smp[1] == $past(st_r.rxs2);
  endproperty
  a_rx_second_sample: assert property (p_rx_second_sample)
    else $error("second sample not taken");

  property p_rx_wait_quiet;
    st_r.rstate == ASP_RX_WAIT |-> !rx_load;
  endproperty
  a_rx_wait_quiet: assert property (p_rx_wait_quiet)
    else $error("stop bit time changed the buffer");

  property p_rx_buffer_hold;
    !rx_load |=> $stable(st_r.serial_buffer);
  endproperty
  a_rx_buffer_hold: assert property (p_rx_buffer_hold)
    else $error("buffer changed without accepted frame");

  c_tx_frame: cover property (tx_final);
  c_rx_accept: cover property (rx_load);
  c_rx_abort: cover property (rx_abort);
  c_rx_filtered: cover property (rx_vote_pt && st_r.rstate == ASP_RX_BITS && !st_r.rsr[8] && !rx_load);
  c_rx_wait_end: cover property (rx_vote_pt && st_r.rstate == ASP_RX_WAIT);
endmodule : asp_uart
`default_nettype wire

//--- verification/asp_remote.sv
// remote serial transceiver on the far side of the line
`timescale 1ns/1ps
`default_nettype none
module asp_remote (
  input wire logic clock,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  // start bit, then nb bits lsb first, bitclk clocks each
  task automatic send(input int bitclk, input int nb, input logic [10:0] bits);
    line_out <= 1'b0;
    repeat (bitclk) @(posedge clock);
    for (int i = 0; i < nb; i++) begin
      line_out <= bits[i];
      repeat (bitclk) @(posedge clock);
    end
    line_out <= 1'b1;
  endtask : send
  // wait for a start edge, sample each bit at its centre
  task automatic recv(input int bitclk, input int nb, output logic start, output logic [10:0] bits);
    bits = 11'h000;
    @(negedge line_in);
    repeat (bitclk / 2) @(posedge clock);
    start = line_in;
    for (int i = 0; i < nb; i++) begin
      repeat (bitclk) @(posedge clock);
      bits[i] = line_in;
    end
  endtask : recv
endmodule : asp_remote
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the asynchronous serial port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import asp_pkg::*;
  typedef struct {logic [7:0] ctrl; logic [7:0] baud; int txb; int rxb; logic [7:0] data;} asp_row_s;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  asp_bus_s bus = '0;
  logic [7:0] rdata;
  logic rxd;
  logic txd;
  logic serial_irq;
  logic timer1_ovf = 1'b0;
  logic timer2_ovf = 1'b0;
  int pc = 0;
  int n_errors = 0;
  int checks = 0;
  int nb;
  logic st;
  logic nin;
  logic [10:0] v;
  logic [10:0] got;
  logic [10:0] w;
  asp_row_s rows [6] = '{
    '{8'h50, 8'h00, 64, 64, 8'hA5},
    '{8'h50, 8'h01, 32, 32, 8'h3C},
    '{8'h90, 8'h00, 64, 64, 8'h81},
    '{8'h98, 8'h01, 32, 32, 8'h5A},
    '{8'hD8, 8'h02, 48, 64, 8'hC3},
    '{8'hD0, 8'h06, 48, 48, 8'h0F}};
  always #5 clock = ~clock;
  // timer 1 overflows every 2 clocks, timer 2 every 3
  always @(posedge clock) begin
    pc <= pc + 1;
    timer1_ovf <= pc[0];
    timer2_ovf <= (pc % 3 == 0);
  end
  asp_uart dut (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata), .rxd(rxd),
    .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf), .txd(txd), .serial_irq(serial_irq));
  asp_remote remote (.clock(clock), .line_in(txd), .line_out(rxd));
  task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] seen);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock);
    bus.wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [10:0] q);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 q = {3'h0, rdata};
    @(posedge clock);
  endtask : rd
  task automatic rx_case(input logic [7:0] c, input int b, input int n, input logic [10:0] word,
    input logic [7:0] eb, input logic [7:0] ec);
    logic [10:0] q;
    wr(2'h0, c);
    remote.send(b, n, word);
    repeat (4) @(posedge clock);
    rd(2'h1, q);
    chk("rx data", {3'h0, eb}, q);
    rd(2'h0, q);
    chk("rx ctrl", {3'h0, ec}, q);
  endtask : rx_case
  task automatic test_done;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (40000) @(posedge clock);
    n_errors++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      nb = rows[i].ctrl[7] ? 10 : 9;
      nin = rows[i].ctrl[7] ? rows[i].ctrl[3] : 1'b1;
      w = rows[i].ctrl[7] ? {2'b01, nin, rows[i].data} : {3'b001, rows[i].data};
      wr(2'h0, rows[i].ctrl);
      wr(2'h2, rows[i].baud);
      fork
        remote.recv(rows[i].txb, nb, st, got);
        wr(2'h1, rows[i].data);
      join
      chk("tx start", 11'h000, {10'h000, st});
      chk("tx frame", w, got);
      rd(2'h0, v);
      chk("tx done", {3'h0, rows[i].ctrl | 8'h02}, v);
      chk("irq", 11'h001, {10'h000, serial_irq});
      rx_case(rows[i].ctrl, rows[i].rxb, nb, w, rows[i].data, rows[i].ctrl | 8'h01 | {5'h00, nin, 2'h0});
      $display("row %0d done", i);
    end
    rx_case(8'h51, 48, 9, 11'h177, 8'h0F, 8'h51);
    rx_case(8'h70, 48, 9, 11'h066, 8'h0F, 8'h70);
    rx_case(8'hF0, 48, 10, 11'h266, 8'h0F, 8'hF0);
    rx_case(8'hF0, 48, 10, 11'h199, 8'h99, 8'hF5);
    $display("drop cases done");
    wr(2'h0, 8'h50);
    remote.send(8, 0, 11'h000);
    repeat (200) @(posedge clock);
    rd(2'h0, v);
    chk("false start", 11'h050, v);
    rx_case(8'h50, 48, 9, 11'h1A5, 8'hA5, 8'h55);
    wr(2'h3, 8'hFF);
    rd(2'h3, v);
    chk("unmapped", 11'h000, v);
    rd(2'h0, v);
    chk("ctrl kept", 11'h055, v);
    wr(2'h0, 8'h50);
    chk("irq cleared", 11'h000, {10'h000, serial_irq});
    wr(2'h0, 8'h52);
    chk("irq by software", 11'h001, {10'h000, serial_irq});
    $display("flag cases done");
    rst_n <= 1'b0;
    @(posedge clock);
    chk("reset txd", 11'h001, {10'h000, txd});
    chk("reset irq", 11'h000, {10'h000, serial_irq});
    rst_n <= 1'b1;
    @(posedge clock);
    rd(2'h0, v);
    chk("reset ctrl", 11'h000, v);
    rd(2'h2, v);
    chk("reset baud", 11'h000, v);
    rd(2'h1, v);
    chk("reset buffer", 11'h000, v);
    $display("reset case done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
